// ==== hw/swm_master.sv ====
/*
 * Single-line bus master: reset, byte, search-triplet and program commands
 * from a host command FIFO, results returned on a result port.
 * Assumes an external pullup, a 12 V switch driven by prog_en_o, and a
 * line input synchronous to sys_clk_i.
 */
// Summary of operation
// RULE1 - Line idles high; slots start only after the line is seen high again.
// RULE2 - Host sequences reset, ROM command, memory command, then data.
// RULE3 - ROM selection is one 8-bit code sent after presence.
// RULE4 - Read code 33H: host reads 64 code bits as bytes.
// RULE5 - Match code 55H: host sends 64 code bits as bytes.
// RULE6 - Skip code CCH: no code bits follow.
// RULE7 - Search F0H: read bit, read complement, write chosen direction.
// RULE8 - Devices pull low only; line is wired-AND.
// RULE9 - Master holds reset low at least 480 us then releases.
// RULE10 - Presence expected 15-60 us after release, lasting 60-240 us.
// RULE11 - After presence, next byte is a ROM selection command.
// RULE12 - Reset low plus rise stays under 960 us.
// RULE13 - Master starts every transfer except presence.
// RULE14 - Every bit slot begins with the master pulling low.
// RULE15 - Write zero holds low 60 to under 120 us; one releases early.
// RULE16 - Read slot samples the line before 15 us after falling edge; code samples at 15 us (2 us low plus 13 us).
// RULE17 - Program pulse: 12 V for 480 us, then back to pullup idle.
// RULE18 - Program pulse commits the device scratchpad byte.
// RULE19 - Slot timing keeps the rate at or below 16.3 kbps.
// RULE20 - Slots last 60-120 us with at least 1 us recovery.
// RULE21 - A reset aborts any command in progress.
// RULE22 - Bytes move least significant bit first.
module swm_master #(
	parameter int DEPTH = swm_pkg::FIFO_DEPTH
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [2:0] cmd_op_i,
	input  wire logic [7:0] cmd_data_i,
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	output logic [7:0]      rsp_data_o,
	output logic            rsp_valid_o,
	input  wire logic       line_i,
	output logic            line_o,
	output logic            line_oe_o,
	output logic            prog_en_o,
	output logic            busy_o
);
	typedef enum {MS_IDLE, MS_ISSUE, MS_WAIT, MS_NEXT, MS_REPLY} swm_ms_e;

	localparam int CMD_W = 3 + swm_pkg::DATA_W;

	swm_ms_e            st_r;
	logic [2:0]         op_r;
	logic [7:0]         shreg_r;
	logic [7:0]         rx_r;
	logic [2:0]         idx_r;
	logic [1:0]         step_r;
	logic [1:0]         trip_r;
	logic [CMD_W-1:0]   q_data;
	logic               q_valid;
	logic               q_ready;
	logic               fifo_in_ready;
	logic               sl_start_r;
	logic [1:0]         sl_prim_r;
	logic               sl_bit_r;
	logic               sl_busy;
	logic               sl_done;
	logic               sl_bit;
	logic               sl_pull;
	logic               sl_prog;

	// Host-visible ready is registered; a push only lands when room exists
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_ready_o <= 1'b0;
		end else begin
			cmd_ready_o <= fifo_in_ready && !(cmd_valid_i && cmd_ready_o);
		end
	end

	swm_fifo #(
		.WIDTH (CMD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   ({cmd_op_i, cmd_data_i}),
		.in_valid_i  (cmd_valid_i && cmd_ready_o),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (q_data),
		.out_valid_o (q_valid),
		.out_ready_i (q_ready)
	);

	assign q_ready = (st_r == MS_IDLE);

	swm_slot u_slot (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (sl_start_r),
		.prim_i     (sl_prim_r),
		.bit_i      (sl_bit_r),
		.line_i     (line_i),
		.busy_o     (sl_busy),
		.done_o     (sl_done),
		.bit_o      (sl_bit),
		.pull_low_o (sl_pull),
		.prog_en_o  (sl_prog)
	);

	// Line pin: open-drain low only, never driven high; prog_en_o is a plain output
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_o    <= 1'b0;
			line_oe_o <= 1'b0;
			prog_en_o <= 1'b0;
		end else begin
			line_o    <= 1'b0; // [RULE8]
			line_oe_o <= sl_pull; // [RULE13]
			prog_en_o <= sl_prog; // [RULE17] [RULE18]
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r        <= MS_IDLE;
			op_r        <= swm_pkg::OP_RESET;
			shreg_r     <= '0;
			rx_r        <= '0;
			idx_r       <= '0;
			step_r      <= '0;
			trip_r      <= '0;
			sl_start_r  <= 1'b0;
			sl_prim_r   <= swm_pkg::PRIM_RESET;
			sl_bit_r    <= 1'b1;
			rsp_data_o  <= '0;
			rsp_valid_o <= 1'b0;
			busy_o      <= 1'b0;
		end else begin
			sl_start_r  <= 1'b0;
			rsp_valid_o <= 1'b0;
			case (st_r)
				MS_IDLE: begin
					busy_o <= q_valid;
					if (q_valid) begin
						op_r    <= q_data[CMD_W-1 -: 3];
						shreg_r <= q_data[7:0];
						rx_r    <= '0;
						idx_r   <= '0;
						step_r  <= '0;
						trip_r  <= '0;
						st_r    <= MS_ISSUE;
					end
				end
				MS_ISSUE: begin
					sl_start_r <= 1'b1;
					case (op_r)
						swm_pkg::OP_RESET: begin
							sl_prim_r <= swm_pkg::PRIM_RESET; // [RULE21] [RULE11]
						end
						swm_pkg::OP_WRITE: begin
							sl_prim_r <= swm_pkg::PRIM_WRITE;
							sl_bit_r  <= shreg_r[idx_r]; // [RULE22] [RULE3]
						end
						swm_pkg::OP_READ: begin
							sl_prim_r <= swm_pkg::PRIM_READ;
						end
						swm_pkg::OP_TRIPLET: begin
							sl_prim_r <= (step_r == 2'd2) ? swm_pkg::PRIM_WRITE
							                              : swm_pkg::PRIM_READ;
							// Direction: forced by single answer, else host choice
							sl_bit_r  <= (trip_r == 2'b01) ? 1'b1 :
							             (trip_r == 2'b10) ? 1'b0 : shreg_r[0]; // [RULE7]
						end
						default: begin
							sl_prim_r <= swm_pkg::PRIM_PROG;
						end
					endcase
					st_r <= MS_WAIT;
				end
				MS_WAIT: begin
					if (sl_done && !sl_busy) begin
						st_r <= MS_NEXT;
						if (op_r == swm_pkg::OP_READ) begin
							rx_r[idx_r] <= sl_bit; // [RULE22] [RULE4]
						end
						if (op_r == swm_pkg::OP_TRIPLET && step_r != 2'd2) begin
							trip_r[step_r[0]] <= sl_bit;
						end
						if (op_r == swm_pkg::OP_RESET) begin
							rx_r <= {7'h00, sl_bit};
						end
					end
				end
				MS_NEXT: begin
					st_r <= MS_REPLY;
					case (op_r)
						swm_pkg::OP_WRITE, swm_pkg::OP_READ: begin
							// Eight slots per byte, as for ROM codes and code bytes
							if (idx_r != 3'd7) begin
								idx_r <= idx_r + 1'b1; // [RULE5] [RULE6]
								st_r  <= MS_ISSUE;
							end
						end
						swm_pkg::OP_TRIPLET: begin
							if (step_r != 2'd2) begin
								step_r <= step_r + 1'b1;
								st_r   <= MS_ISSUE;
							end
						end
						default: st_r <= MS_REPLY;
					endcase
				end
				MS_REPLY: begin
					rsp_valid_o <= 1'b1; // [RULE2]
					if (op_r == swm_pkg::OP_TRIPLET) begin
						rsp_data_o <= {5'h00, sl_bit_r, trip_r[1], trip_r[0]};
					end else if (op_r == swm_pkg::OP_WRITE) begin
						rsp_data_o <= shreg_r;
					end else if (op_r == swm_pkg::OP_PROGRAM) begin
						rsp_data_o <= '0;
					end else begin
						rsp_data_o <= rx_r;
					end
					st_r   <= MS_IDLE;
					busy_o <= 1'b0;
				end
				default: st_r <= MS_IDLE;
			endcase
		end
	end
endmodule // swm_master

// ==== hw/swm_pkg.sv ====
/*
 * Constants for the single-line bus master: link timing, ROM selection
 * codes, command and slot primitive codes.
 * Assumes a 100 MHz system clock; all cycle counts derive from it.
 */
package swm_pkg;
	localparam int CLK_MHZ = 100;

	// Times in microseconds
	localparam int RESET_LOW_US      = 480;
	localparam int RESET_HIGH_US     = 480;
	localparam int PRESENCE_WAIT_US  = 15;
	localparam int PRESENCE_SPAN_US  = 60;
	localparam int PRESENCE_END_US   = 300;
	localparam int ONE_LOW_US        = 2;
	localparam int READ_LOW_US       = 2;
	localparam int READ_SAMPLE_US    = 13;
	localparam int ZERO_LOW_US       = 65;
	localparam int BIT_SLOT_US       = 70;
	localparam int SLOT_RECOVERY_US  = 2;
	localparam int PROG_PULSE_US     = 480;
	localparam int PROG_DELAY_US     = 5;

	// Cycle counts
	localparam int RESET_LOW_CYC     = RESET_LOW_US * CLK_MHZ;
	localparam int RESET_HIGH_CYC    = RESET_HIGH_US * CLK_MHZ;
	localparam int PRESENCE_WAIT_CYC = PRESENCE_WAIT_US * CLK_MHZ;
	localparam int PRESENCE_END_CYC  = PRESENCE_END_US * CLK_MHZ;
	localparam int ONE_LOW_CYC       = ONE_LOW_US * CLK_MHZ;
	localparam int READ_LOW_CYC      = READ_LOW_US * CLK_MHZ;
	localparam int READ_SAMPLE_CYC   = READ_SAMPLE_US * CLK_MHZ;
	localparam int ZERO_LOW_CYC      = ZERO_LOW_US * CLK_MHZ;
	localparam int BIT_SLOT_CYC      = BIT_SLOT_US * CLK_MHZ;
	localparam int SLOT_RECOVERY_CYC = SLOT_RECOVERY_US * CLK_MHZ;
	localparam int PROG_PULSE_CYC    = PROG_PULSE_US * CLK_MHZ;
	localparam int PROG_DELAY_CYC    = PROG_DELAY_US * CLK_MHZ;

	localparam int CNT_W = 16;

	// ROM selection codes
	localparam logic [7:0] ROM_READ   = 8'h33;
	localparam logic [7:0] ROM_MATCH  = 8'h55;
	localparam logic [7:0] ROM_SKIP   = 8'hcc;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;

	// Host commands on cmd_op_i
	localparam logic [2:0] OP_RESET   = 3'h0;
	localparam logic [2:0] OP_WRITE   = 3'h1;
	localparam logic [2:0] OP_READ    = 3'h2;
	localparam logic [2:0] OP_TRIPLET = 3'h3;
	localparam logic [2:0] OP_PROGRAM = 3'h4;

	// Link primitive codes for the slot engine
	localparam logic [1:0] PRIM_RESET = 2'h0;
	localparam logic [1:0] PRIM_WRITE = 2'h1;
	localparam logic [1:0] PRIM_READ  = 2'h2;
	localparam logic [1:0] PRIM_PROG  = 2'h3;

	localparam int FIFO_DEPTH = 8;
	localparam int DATA_W     = 8;
endpackage

// ==== hw/swm_fifo.sv ====
/*
 * Small synchronous FIFO, flip-flop storage, valid/ready on both sides.
 * Assumes one clock; DEPTH a power of two.
 */
module swm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // swm_fifo

// ==== hw/swm_slot.sv ====
/*
 * Slot engine: one reset/presence sequence, one write slot, one read
 * slot or one program pulse per start.
 * Assumes the line input is already synchronous to sys_clk_i.
 */
module swm_slot (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [1:0] prim_i,
	input  wire logic       bit_i,
	input  wire logic       line_i,
	output logic            busy_o,
	output logic            done_o,
	output logic            bit_o,
	output logic            pull_low_o,
	output logic            prog_en_o
);
	typedef enum {SL_IDLE, SL_LOW, SL_WAIT, SL_PROG, SL_REC} swm_sl_e;

	swm_sl_e                   st_r;
	logic [1:0]                prim_r;
	logic                      val_r;
	logic [swm_pkg::CNT_W-1:0] cnt_r;
	logic [swm_pkg::CNT_W-1:0] low_len;

	function automatic logic [swm_pkg::CNT_W-1:0] cyc(input int n);
		return swm_pkg::CNT_W'(n);
	endfunction

	always_comb begin
		case (prim_r)
			swm_pkg::PRIM_RESET: low_len = cyc(swm_pkg::RESET_LOW_CYC);
			swm_pkg::PRIM_READ:  low_len = cyc(swm_pkg::READ_LOW_CYC);
			swm_pkg::PRIM_WRITE: low_len = val_r ? cyc(swm_pkg::ONE_LOW_CYC)
			                                     : cyc(swm_pkg::ZERO_LOW_CYC);
			default:             low_len = cyc(swm_pkg::PROG_DELAY_CYC);
		endcase
	end

	assign busy_o = (st_r != SL_IDLE);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r       <= SL_IDLE;
			prim_r     <= swm_pkg::PRIM_RESET;
			val_r      <= 1'b1;
			cnt_r      <= '0;
			done_o     <= 1'b0;
			bit_o      <= 1'b0;
			pull_low_o <= 1'b0;
			prog_en_o  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (st_r)
				SL_IDLE: begin
					if (start_i) begin
						prim_r <= prim_i;
						val_r  <= bit_i;
						cnt_r  <= '0;
						bit_o  <= 1'b0;
						// Program pulse never drives low; wait then raise the enable
						pull_low_o <= (prim_i != swm_pkg::PRIM_PROG); // [RULE14]
						st_r   <= SL_LOW;
					end
				end
				SL_LOW: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == low_len - 1'b1) begin
						pull_low_o <= 1'b0; // [RULE15] [RULE9]
						cnt_r      <= '0;
						st_r       <= (prim_r == swm_pkg::PRIM_PROG) ? SL_PROG : SL_WAIT;
						prog_en_o  <= (prim_r == swm_pkg::PRIM_PROG);
					end
				end
				SL_PROG: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == cyc(swm_pkg::PROG_PULSE_CYC) - 1'b1) begin
						prog_en_o <= 1'b0; // [RULE17]
						cnt_r     <= '0;
						st_r      <= SL_REC;
					end
				end
				SL_WAIT: begin
					cnt_r <= cnt_r + 1'b1;
					// Presence sampled inside the response window
					if (prim_r == swm_pkg::PRIM_RESET &&
					    cnt_r >= cyc(swm_pkg::PRESENCE_WAIT_CYC) &&
					    cnt_r <= cyc(swm_pkg::PRESENCE_END_CYC) && !line_i) begin
						bit_o <= 1'b1; // [RULE10]
					end
					if (prim_r == swm_pkg::PRIM_READ &&
					    cnt_r == cyc(swm_pkg::READ_SAMPLE_CYC)) begin
						bit_o <= line_i; // [RULE16]
					end
					if (prim_r == swm_pkg::PRIM_RESET) begin
						if (cnt_r == cyc(swm_pkg::RESET_HIGH_CYC) - 1'b1) begin
							cnt_r <= '0;
							st_r  <= SL_IDLE;
							done_o <= 1'b1;
						end
					end else if (cnt_r == cyc(swm_pkg::BIT_SLOT_CYC) - low_len) begin
						cnt_r <= '0; // [RULE20] [RULE19]
						st_r  <= SL_REC;
					end
				end
				SL_REC: begin
					cnt_r <= cnt_r + 1'b1;
					// Line must be back high before the next slot starts
					if (cnt_r >= cyc(swm_pkg::SLOT_RECOVERY_CYC) && line_i) begin
						st_r   <= SL_IDLE; // [RULE1]
						done_o <= 1'b1;
					end
				end
				default: st_r <= SL_IDLE;
			endcase
		end
	end
endmodule // swm_slot

// ==== testbench/swm_master_asserts.sv ====
/* Timing checker for the single-line bus master ports.
 * Assumes the bench feeds line_i with the resolved bus level. */
module swm_master_chk #(
	parameter int DEPTH = swm_pkg::FIFO_DEPTH
) (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic [2:0] cmd_op_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic       cmd_valid_i,
	input wire logic       cmd_ready_o,
	input wire logic [7:0] rsp_data_o,
	input wire logic       rsp_valid_o,
	input wire logic       line_i,
	input wire logic       line_o,
	input wire logic       line_oe_o,
	input wire logic       prog_en_o,
	input wire logic       busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SAT = 200000;
	int unsigned oe_cnt;
	int unsigned hi_cnt;
	int unsigned rise_cnt;
	int unsigned prog_cnt;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			oe_cnt <= 0;
		else
			oe_cnt <= line_oe_o ? oe_cnt + 1 : 0;
	end
	// Saturated at reset so the first slot after reset is not judged
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			hi_cnt <= SAT;
		else
			hi_cnt <= !line_i ? 0 : (hi_cnt < SAT ? hi_cnt + 1 : hi_cnt);
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rise_cnt <= SAT;
		else
			rise_cnt <= (line_oe_o && oe_cnt == 0) ? 1 : (rise_cnt < SAT ? rise_cnt + 1 : rise_cnt);
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			prog_cnt <= 0;
		else
			prog_cnt <= prog_en_o ? prog_cnt + 1 : 0;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence slot_start_s;
		$rose(line_oe_o);
	endsequence
	sequence prog_end_s;
		$fell(prog_en_o);
	endsequence

	drive_pull_a: assert property (line_oe_o |-> !line_o && !prog_en_o)
		else $error("line driven other than low");
	low_len_a: assert property ($fell(line_oe_o) |-> oe_cnt inside
		{[100:1499], [6000:11999], [48000:95999]}) else $error("low pulse length illegal");
	recovery_a: assert property (slot_start_s |-> hi_cnt >= 100)
		else $error("slot started without recovery");
	slot_rate_a: assert property (slot_start_s |-> rise_cnt >= 6135)
		else $error("slot rate too high");
	quiet_idle_a: assert property (!busy_o |-> !line_oe_o && !prog_en_o)
		else $error("line activity while idle");
	prog_len_a: assert property (prog_end_s |-> prog_cnt >= 48000 && prog_cnt <= 48001)
		else $error("program pulse length wrong");
	prog_delay_a: assert property ($rose(prog_en_o) |-> hi_cnt >= 500)
		else $error("program pulse too soon");
	rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
		else $error("response longer than one cycle");
endmodule // swm_master_chk

bind swm_master swm_master_chk #(.DEPTH(DEPTH)) u_chk (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i),
	.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .rsp_data_o(rsp_data_o),
	.rsp_valid_o(rsp_valid_o), .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o),
	.prog_en_o(prog_en_o), .busy_o(busy_o)
);

// ==== testbench/swm_dev_model.sv ====
/* Behavioural slave on the single line: presence, ROM selection, program pulse.
 * Assumes bus_i is the resolved wired-AND level, 100 MHz clk_i for timing. */
module swm_dev_model #(
	parameter logic [63:0] CODE = 64'h9e00_0000_0123_4502 // Arbitrary value
) (
	input  wire logic clk_i,
	input  wire logic bus_i,
	input  wire logic prog_i,
	output logic      pull_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cmd_r = 8'h00;
	logic [7:0] cell_r = 8'hff;
	logic [7:0] scratch_r = 8'h3c;
	logic       smp;
	logic       tx;
	int         st = 0;
	int         ph = 0;
	int         idx = 0;
	int         n;
	int         prog_n = 0;

	initial pull_o = 1'b0;

	task automatic slot(input logic b);
		case (st)
			1: begin
				cmd_r = {b, cmd_r[7:1]};
				idx++;
				if (idx == 8) begin
					idx = 0;
					case (cmd_r)
						swm_pkg::ROM_READ:   st = 3;
						swm_pkg::ROM_MATCH:  st = 5;
						swm_pkg::ROM_SKIP:   st = 4;
						swm_pkg::ROM_SEARCH: st = 2;
						default:             st = 0;
					endcase
				end
			end
			2: begin
				if (ph == 2 && b != CODE[idx])
					st = 0;
				if (ph == 2)
					idx++;
				ph = (ph + 1) % 3;
			end
			3: begin
				idx++;
				st = (idx == 64) ? 4 : 3;
			end
			5: begin
				st = (b != CODE[idx]) ? 0 : (idx == 63 ? 4 : 5);
				idx++;
			end
			default: ;
		endcase
	endtask

	// Only ever reacts to a master falling edge, never starts a slot itself
	always begin
		@(negedge bus_i);
		tx = CODE[idx] ^ (st == 2 && ph == 1);
		if ((st == 3 || (st == 2 && ph < 2)) && !tx)
			pull_o = 1'b1;
		repeat (3000) @(posedge clk_i);
		smp = bus_i;
		pull_o = 1'b0;
		n = 3000;
		while (bus_i !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		if (n > 12000) begin
			repeat (2000) @(posedge clk_i);
			pull_o = 1'b1;
			repeat (10000) @(posedge clk_i);
			pull_o = 1'b0;
			st = 1;
			idx = 0;
			ph = 0;
		end else
			slot(smp);
	end

	always @(posedge prog_i) begin
		cell_r = scratch_r;
		prog_n++;
	end
endmodule // swm_dev_model

// ==== testbench/tb_swm_master.sv ====
/* Self-checking bench for swm_master against the behavioural slave.
 * Assumes a pullup on the line, modelled by the resolve expression. */
module tb_swm_master;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] DEV_CODE = 64'h9e00_0000_0123_4502; // Arbitrary value
	logic       sys_clk = 1'b0;
	logic       rst_n;
	logic [2:0] cmd_op;
	logic [7:0] cmd_data;
	logic       cmd_valid;
	logic       cmd_ready;
	logic [7:0] rsp_data;
	logic       rsp_valid;
	logic       line_o;
	logic       line_oe;
	logic       prog_en;
	logic       busy;
	logic       dev_pull;
	logic       line_w;
	int         bad_count = 0;
	int         cmp_count = 0;

	always #5 sys_clk = ~sys_clk;
	assign line_w = !((line_oe & ~line_o) | dev_pull);

	swm_master u_dut (
		.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cmd_op_i(cmd_op), .cmd_data_i(cmd_data),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .rsp_data_o(rsp_data),
		.rsp_valid_o(rsp_valid), .line_i(line_w), .line_o(line_o), .line_oe_o(line_oe),
		.prog_en_o(prog_en), .busy_o(busy)
	);
	swm_dev_model #(.CODE(DEV_CODE)) u_dev (
		.clk_i(sys_clk), .bus_i(line_w), .prog_i(prog_en), .pull_o(dev_pull)
	);

	task automatic summarize();
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Leaves valid up so back-to-back offers need no extra edge
	task automatic send(input logic [2:0] op, input logic [7:0] d);
		int n;
		n = 0;
		cmd_op = op;
		cmd_data = d;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 100) begin
			bad_count++;
			summarize();
		end
		@(posedge sys_clk);
		#1;
	endtask

	task automatic expect_rsp(input string what, input logic [7:0] exp);
		int n;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 120000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 120000) begin
			bad_count++;
			summarize();
		end
		check(what, rsp_data, exp);
		@(posedge sys_clk);
		#1;
	endtask

	task automatic t_fill();
		int n;
		int taken;
		taken = 0;
		cmd_op = swm_pkg::OP_WRITE;
		cmd_data = 8'h00;
		cmd_valid = 1'b1;
		for (n = 0; n < 40; n++) begin
			if (cmd_ready === 1'b1)
				taken++;
			@(posedge sys_clk);
			#1;
		end
		check("fifo_full", {7'h00, cmd_ready}, 8'h00);
		check("fifo_taken", {7'h00, taken >= 8 && taken <= 10}, 8'h01);
		check("fill_busy", {7'h00, busy}, 8'h01);
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		#2;
		check("abort_line", {6'h00, line_oe, prog_en}, 8'h00);
		repeat (4) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		@(posedge sys_clk);
		#1;
		check("abort_idle", {6'h00, cmd_ready, busy}, 8'h02);
	endtask

	task automatic t_search();
		send(swm_pkg::OP_RESET, 8'h00);
		send(swm_pkg::OP_WRITE, swm_pkg::ROM_SEARCH);
		send(swm_pkg::OP_TRIPLET, 8'h00);
		send(swm_pkg::OP_TRIPLET, 8'h01);
		send(swm_pkg::OP_PROGRAM, 8'h00);
		cmd_valid = 1'b0;
		expect_rsp("presence", 8'h01);
		expect_rsp("rom_echo", swm_pkg::ROM_SEARCH);
		expect_rsp("triplet0", {5'h00, DEV_CODE[0], ~DEV_CODE[0], DEV_CODE[0]});
		expect_rsp("triplet1", {5'h00, DEV_CODE[1], ~DEV_CODE[1], DEV_CODE[1]});
		expect_rsp("program", 8'h00);
		check("rom_rx", u_dev.cmd_r, swm_pkg::ROM_SEARCH);
		check("search_kept", 8'(u_dev.st), 8'h02);
		check("search_bits", 8'(u_dev.idx), 8'h02);
		check("prog_seen", 8'(u_dev.prog_n), 8'h01);
	endtask

	// Read path: fresh reset, read-code command, then the family byte
	task automatic t_read();
		send(swm_pkg::OP_RESET, 8'h00);
		send(swm_pkg::OP_WRITE, swm_pkg::ROM_READ);
		send(swm_pkg::OP_READ, 8'h00);
		cmd_valid = 1'b0;
		expect_rsp("presence2", 8'h01);
		expect_rsp("rom_echo2", swm_pkg::ROM_READ);
		expect_rsp("family_byte", DEV_CODE[7:0]);
		check("read_state", 8'(u_dev.st), 8'h03);
		check("read_bits", 8'(u_dev.idx), 8'h08);
	endtask

	initial begin
		rst_n = 1'b0;
		cmd_op = 3'h0;
		cmd_data = 8'h00;
		cmd_valid = 1'b0;
		repeat (16) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		t_fill();
		t_search();
		t_read();
		summarize();
	end
endmodule // tb_swm_master
